// File: rtl/stm_counter.sv
// 16-bit up counter: clears on start, holds when off
module stm_counter #(
    parameter int W = 16
) (
    input  wire logic         i_mclk,    // system clock
    input  wire logic         i_resetn,  // sync reset, active low
    input  wire logic         i_ce,      // clock enable
    input  wire logic         i_tick,    // timer clock active edge
    input  wire logic         i_start,   // counter-on rising edge
    input  wire logic         i_run,     // counter-on level
    input  wire logic         i_clear,   // clear on this tick
    output logic [W-1:0]      o_count    // counter value
);
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_count <= '0;
        end else if (i_ce) begin
            if (i_start) begin
                o_count <= '0;                                  // RULE_18
            end else if (i_run && i_tick) begin
                if (i_clear) begin
                    o_count <= '0;
                end else begin
                    o_count <= o_count + W'(1);                 // RULE_20
                end
            end
        end
    end
endmodule

// File: rtl/stm_match.sv
// match detection on the current count; compare P checks the upper byte, with the lower byte at FF
module stm_match (
    input  wire logic [15:0]        i_count,   // counter value
    input  wire logic [15:0]        i_cmp_a,   // compare A value
    input  wire logic [7:0]         i_cmp_p,   // compare P value
    output stm_pkg::stm_match_t     o_match    // match terms
);
    always_comb begin
        // the next tick would make the counter reach the compare value
        o_match.match_a  = (i_cmp_a != stm_pkg::CNT_ZERO) &&
                           (i_count + stm_pkg::CNT_ONE == i_cmp_a);          // RULE_21 RULE_06
        o_match.match_p  = (i_cmp_p != stm_pkg::CMPP_ZERO) &&
                           (i_count[7:0] == stm_pkg::BYTE_ONES) &&
                           (i_count[15:8] + stm_pkg::BYTE_ONES == i_cmp_p - 8'h01
                            + stm_pkg::BYTE_ONES);                           // RULE_01 RULE_21
        o_match.overflow = (i_count == stm_pkg::CNT_MAX);
    end
endmodule

// File: rtl/stm_pkg.sv
package stm_pkg;
    localparam int   CNT_W      = 16;
    localparam int   BYTE_W     = 8;
    localparam int   ADDR_W     = 3;

    // register addresses
    localparam logic [2:0] ADDR_CTRL0  = 3'h0;
    localparam logic [2:0] ADDR_CTRL1  = 3'h1;
    localparam logic [2:0] ADDR_CNT_LO = 3'h2;
    localparam logic [2:0] ADDR_CNT_HI = 3'h3;
    localparam logic [2:0] ADDR_CMPA_LO = 3'h4;
    localparam logic [2:0] ADDR_CMPA_HI = 3'h5;
    localparam logic [2:0] ADDR_CMPP   = 3'h6;
    localparam logic [2:0] ADDR_FLAGS  = 3'h7;

    // field positions
    localparam int   POS_ON      = 3;
    localparam int   POS_MODE_HI = 7;
    localparam int   POS_MODE_LO = 6;
    localparam int   POS_PIN_HI  = 5;
    localparam int   POS_PIN_LO  = 4;
    localparam int   POS_OLVL    = 3;
    localparam int   POS_INV     = 2;
    localparam int   POS_SWAP    = 1;
    localparam int   POS_CLRSRC  = 0;
    localparam int   POS_FLAG_A  = 0;
    localparam int   POS_FLAG_P  = 1;

    localparam logic [7:0]  RESET_BYTE = 8'h00;
    localparam logic [15:0] CNT_ZERO   = 16'h0000;
    localparam logic [15:0] CNT_ONE    = 16'h0001;
    localparam logic [15:0] CNT_MAX    = 16'hFFFF;
    localparam logic [7:0]  CMPP_ZERO  = 8'h00;
    localparam logic [7:0]  BYTE_ONES  = 8'hFF;

    typedef enum logic [1:0] {
        STM_MODE_CMP   = 2'h0,
        STM_MODE_CAPT  = 2'h1,
        STM_MODE_PWM   = 2'h2,
        STM_MODE_TIMER = 2'h3
    } stm_mode_t;

    // pin function, compare mode / pwm mode meaning
    localparam logic [1:0] PIN_NONE_OR_INACT = 2'h0;
    localparam logic [1:0] PIN_LOW_OR_ACT    = 2'h1;
    localparam logic [1:0] PIN_HIGH_OR_PWM   = 2'h2;
    localparam logic [1:0] PIN_TOGGLE        = 2'h3;

    typedef struct packed {
        logic [1:0] timer_mode_sel;
        logic [1:0] pin_function_sel;
        logic       output_level_ctrl;
        logic       output_invert;
        logic       duty_period_swap;
        logic       clear_source_sel;
    } stm_ctrl_t;

    typedef struct packed {
        logic match_a;
        logic match_p;
        logic overflow;
    } stm_match_t;
endpackage

// File: rtl/stm_timer.sv
// Operation
// (RULE_01) compare P matches counter upper byte
// (RULE_02) compare mode clears counter per clear source
// (RULE_03) source 0: clear on P, raise both
// (RULE_04) source 1: clear on A, only A flag
// (RULE_05) software keeps compare A nonzero here
// (RULE_06) compare A zero: overflow, no A flag
// (RULE_07) pin changes only on A match
// (RULE_08) A match sets, clears or toggles pin
// (RULE_09) counter start loads initial pin level
// (RULE_10) mode 11 counts but leaves pin alone
// (RULE_11) software selects PWM via mode, pin fields
// (RULE_12) PWM ignores clear source; swap exchanges roles
// (RULE_13) PWM raises A and P flags
// (RULE_14) PWM level bit sets active polarity
// (RULE_15) invert bit inverts the PWM output
// (RULE_16) duty at or above period: 100%
// (RULE_17) forced pin levels keep PWM running
// (RULE_18) start clears counter, stop holds it
// (RULE_19) level bit: initial level or polarity
// (RULE_20) counter increments on each timer tick
// (RULE_21) match when counter equals compare value
//
// Chosen here: strobed register access and the register offsets.
module stm_timer (
    input  wire logic        i_mclk,      // 25 MHz system clock
    input  wire logic        i_resetn,    // sync reset, active low
    input  wire logic        i_ce,        // clock enable, freezes all state
    input  wire logic        i_tick,      // one-cycle timer clock enable
    input  wire logic [2:0]  i_addr,      // register address
    input  wire logic [7:0]  i_wdata,     // write data
    input  wire logic        i_wr,        // write strobe
    input  wire logic        i_rd,        // read strobe
    output logic [7:0]       o_rdata,     // read data, cycle after strobe
    output logic             o_pin,       // output pin level
    output logic             o_pin_oe_n,  // pin driven when low
    output logic             o_match_a_flag, // sticky match A flag
    output logic             o_match_p_flag  // sticky match P flag
);
    stm_pkg::stm_ctrl_t  ctrl;
    logic                counter_on;
    logic                counter_on_d;
    logic [15:0]         compare_a_value;
    logic [7:0]          compare_p_value;
    logic [15:0]         count;
    logic                pin_state;
    stm_pkg::stm_match_t mt;
    stm_pkg::stm_mode_t  mode;
    logic                start;
    logic                step;
    logic                clr;
    logic                hit_a;
    logic                hit_p;
    logic                is_pwm;
    logic                pwm_act;
    logic [16:0]         period_len;
    logic [16:0]         duty_len;
    logic                wr_flags;
    logic                next_pin;

    assign mode   = stm_pkg::stm_mode_t'(ctrl.timer_mode_sel);
    assign is_pwm = (mode == stm_pkg::STM_MODE_PWM);
    assign start  = counter_on && !counter_on_d;
    assign step   = counter_on && i_tick && !start;
    assign wr_flags = i_wr && (i_addr == stm_pkg::ADDR_FLAGS);

    stm_match u_match (
        .i_count (count),
        .i_cmp_a (compare_a_value),
        .i_cmp_p (compare_p_value),
        .o_match (mt)
    );

    // register writes
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            counter_on      <= 1'b0;
            ctrl            <= '0;
            compare_a_value <= stm_pkg::CNT_ZERO;
            compare_p_value <= stm_pkg::RESET_BYTE;
        end else if (i_ce && i_wr) begin
            unique case (i_addr)
                stm_pkg::ADDR_CTRL0:   counter_on <= i_wdata[stm_pkg::POS_ON];
                stm_pkg::ADDR_CTRL1:   ctrl <= i_wdata;
                stm_pkg::ADDR_CMPA_LO: compare_a_value[7:0] <= i_wdata;
                stm_pkg::ADDR_CMPA_HI: compare_a_value[15:8] <= i_wdata;
                stm_pkg::ADDR_CMPP:    compare_p_value <= i_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            counter_on_d <= 1'b0;
        end else if (i_ce) begin
            counter_on_d <= counter_on;
        end
    end

    // match terms that take effect on this tick
    always_comb begin
        hit_a = step && mt.match_a;                             // RULE_06
        // compare P at zero acts as a full 65536 period via overflow
        hit_p = step && ((compare_p_value == stm_pkg::CMPP_ZERO) ? mt.overflow
                                                                 : mt.match_p); // RULE_01
        clr   = 1'b0;
        if (is_pwm) begin
            clr = ctrl.duty_period_swap ? mt.match_a : hit_p;   // RULE_12
            if (ctrl.duty_period_swap && compare_a_value == stm_pkg::CNT_ZERO) begin
                clr = mt.overflow;
            end
        end else if (ctrl.clear_source_sel) begin
            clr = mt.match_a || mt.overflow;                    // RULE_04 RULE_06
        end else begin
            clr = mt.match_p || mt.overflow;                    // RULE_02 RULE_03
        end
    end

    stm_counter #(.W(stm_pkg::CNT_W)) u_counter (
        .i_mclk   (i_mclk),
        .i_resetn (i_resetn),
        .i_ce     (i_ce),
        .i_tick   (i_tick),
        .i_start  (start),
        .i_run    (counter_on),
        .i_clear  (clr),
        .o_count  (count)
    );

    // sticky flags: set wins over a software clear in the same cycle
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_match_a_flag <= 1'b0;
            o_match_p_flag <= 1'b0;
        end else if (i_ce) begin
            if (hit_a) begin
                o_match_a_flag <= 1'b1;                         // RULE_03 RULE_13
            end else if (wr_flags && i_wdata[stm_pkg::POS_FLAG_A]) begin
                o_match_a_flag <= 1'b0;
            end
            if (hit_p && (is_pwm || !ctrl.clear_source_sel)) begin
                o_match_p_flag <= 1'b1;                         // RULE_04 RULE_13
            end else if (wr_flags && i_wdata[stm_pkg::POS_FLAG_P]) begin
                o_match_p_flag <= 1'b0;
            end
        end
    end

    // compare-mode pin action; only counter start and compare A move it
    always_comb begin
        next_pin = pin_state;
        if (start) begin
            next_pin = ctrl.output_level_ctrl;                  // RULE_09 RULE_19
        end else if (hit_a && mode == stm_pkg::STM_MODE_CMP) begin
            unique case (ctrl.pin_function_sel)                 // RULE_07 RULE_08
                stm_pkg::PIN_NONE_OR_INACT: next_pin = pin_state;
                stm_pkg::PIN_LOW_OR_ACT:    next_pin = 1'b0;
                stm_pkg::PIN_HIGH_OR_PWM:   next_pin = 1'b1;
                stm_pkg::PIN_TOGGLE:        next_pin = !pin_state;
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            pin_state <= 1'b0;
        end else if (i_ce) begin
            pin_state <= next_pin;
        end
    end

    // pwm: active while count is below the duty length
    always_comb begin
        period_len = (compare_p_value == stm_pkg::CMPP_ZERO) ? 17'h10000
                                                             : {1'b0, compare_p_value, 8'h00};
        duty_len   = {1'b0, compare_a_value};
        if (ctrl.duty_period_swap) begin                        // RULE_12
            duty_len   = period_len;
            period_len = (compare_a_value == stm_pkg::CNT_ZERO) ? 17'h10000
                                                                : {1'b0, compare_a_value};
        end
        pwm_act = ({1'b0, count} < duty_len) || (duty_len >= period_len); // RULE_16
    end

    // output pin; timer mode leaves the pin undriven
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_pin      <= 1'b0;
            o_pin_oe_n <= 1'b1;
        end else if (i_ce) begin
            o_pin_oe_n <= (mode == stm_pkg::STM_MODE_TIMER) ||
                          (mode == stm_pkg::STM_MODE_CAPT);     // RULE_10
            if (is_pwm) begin
                // level bit picks active high; forced levels keep counting
                unique case (ctrl.pin_function_sel)             // RULE_14 RULE_17
                    stm_pkg::PIN_NONE_OR_INACT:
                        o_pin <= !ctrl.output_level_ctrl ^ ctrl.output_invert;
                    stm_pkg::PIN_LOW_OR_ACT:
                        o_pin <= ctrl.output_level_ctrl ^ ctrl.output_invert;
                    default:
                        o_pin <= (pwm_act ~^ ctrl.output_level_ctrl) ^ ctrl.output_invert; // RULE_15 RULE_19
                endcase
            end else begin
                o_pin <= next_pin ^ ctrl.output_invert;
            end
        end
    end

    // register reads
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_rdata <= stm_pkg::RESET_BYTE;
        end else if (i_ce && i_rd) begin
            unique case (i_addr)
                stm_pkg::ADDR_CTRL0:   o_rdata <= {4'h0, counter_on, 3'h0};
                stm_pkg::ADDR_CTRL1:   o_rdata <= ctrl;
                stm_pkg::ADDR_CNT_LO:  o_rdata <= count[7:0];
                stm_pkg::ADDR_CNT_HI:  o_rdata <= count[15:8];
                stm_pkg::ADDR_CMPA_LO: o_rdata <= compare_a_value[7:0];
                stm_pkg::ADDR_CMPA_HI: o_rdata <= compare_a_value[15:8];
                stm_pkg::ADDR_CMPP:    o_rdata <= compare_p_value;
                stm_pkg::ADDR_FLAGS:   o_rdata <= {6'h00, o_match_p_flag, o_match_a_flag};
            endcase
        end
    end

    a_start_clears: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RULE_18
        (i_ce && start) |=> (count == stm_pkg::CNT_ZERO))
        else $error("counter not cleared on start");

    a_stop_holds: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RULE_18
        (i_ce && !counter_on && !start) |=> $stable(count))
        else $error("stopped counter moved");

    a_count_step: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RULE_20
        (i_ce && step && !clr) |=> (count == $past(count) + stm_pkg::CNT_ONE))
        else $error("counter did not increment");

    a_no_p_flag: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RULE_04
        (i_ce && !is_pwm && ctrl.clear_source_sel && !o_match_p_flag) |=> !o_match_p_flag)
        else $error("match P flag raised with clear source A");

    a_a_zero_noflag: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RULE_06
        (i_ce && compare_a_value == stm_pkg::CNT_ZERO && !o_match_a_flag
         && !(i_wr && i_addr[2:1] == 2'h2)) |=> !o_match_a_flag)
        else $error("match A flag with compare A zero");

    a_flag_set: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RULE_13
        (i_ce && hit_a) |=> o_match_a_flag)
        else $error("match A flag not set");

    a_cmp_clear_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RULE_04
        (i_ce && step && !is_pwm && ctrl.clear_source_sel && mt.match_a)
        |=> (count == stm_pkg::CNT_ZERO))
        else $error("counter not cleared on A match");

    a_timer_nopin: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RULE_10
        (i_ce && mode == stm_pkg::STM_MODE_TIMER) |=> o_pin_oe_n)
        else $error("pin driven in timer mode");

    a_pin_init: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RULE_09
        (i_ce && start && mode == stm_pkg::STM_MODE_CMP)
        |=> (o_pin == ($past(ctrl.output_level_ctrl) ^ $past(ctrl.output_invert))))
        else $error("pin not set to initial level");

    a_p_flag_set: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RULE_03 RULE_13
        (i_ce && hit_p && (is_pwm || !ctrl.clear_source_sel)) |=> o_match_p_flag)
        else $error("match P flag not set");

    a_p_clears_cnt: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RULE_02 RULE_03
        (i_ce && step && !is_pwm && !ctrl.clear_source_sel && mt.match_p)
        |=> (count == stm_pkg::CNT_ZERO))
        else $error("counter not cleared on P match");

    a_p_period: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RULE_01
        (i_ce && hit_p && compare_p_value != stm_pkg::CMPP_ZERO)
        |-> ((count[15:8] == compare_p_value - 8'h01) && (count[7:0] == stm_pkg::BYTE_ONES)))
        else $error("P match off its 256-tick boundary");

    a_a_reached: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RULE_21
        (i_ce && hit_a && !clr) |=> (count == $past(compare_a_value)))
        else $error("counter did not reach compare A");

    a_pin_only_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RULE_07
        (i_ce && !start && !(hit_a && mode == stm_pkg::STM_MODE_CMP)) |=> $stable(pin_state))
        else $error("pin changed without an A match");

    a_pin_high: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RULE_08
        (i_ce && hit_a && mode == stm_pkg::STM_MODE_CMP
         && ctrl.pin_function_sel == stm_pkg::PIN_HIGH_OR_PWM) |=> pin_state)
        else $error("pin not driven high on A match");

    a_pin_low: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RULE_08
        (i_ce && hit_a && mode == stm_pkg::STM_MODE_CMP
         && ctrl.pin_function_sel == stm_pkg::PIN_LOW_OR_ACT) |=> !pin_state)
        else $error("pin not driven low on A match");

    a_pin_toggle: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RULE_08
        (i_ce && hit_a && mode == stm_pkg::STM_MODE_CMP
         && ctrl.pin_function_sel == stm_pkg::PIN_TOGGLE) |=> (pin_state != $past(pin_state)))
        else $error("pin not toggled on A match");

    a_pwm_full: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RULE_16
        (i_ce && is_pwm && ctrl.pin_function_sel == stm_pkg::PIN_HIGH_OR_PWM
         && duty_len >= period_len)
        |=> (o_pin == ($past(ctrl.output_level_ctrl) ^ $past(ctrl.output_invert))))
        else $error("full duty did not hold the pin active");

    a_pwm_active: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RULE_14
        (i_ce && is_pwm && ctrl.pin_function_sel == stm_pkg::PIN_LOW_OR_ACT)
        |=> (o_pin == ($past(ctrl.output_level_ctrl) ^ $past(ctrl.output_invert))))
        else $error("forced active level wrong");

    a_pwm_inactive: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RULE_14 RULE_19
        (i_ce && is_pwm && ctrl.pin_function_sel == stm_pkg::PIN_NONE_OR_INACT)
        |=> (o_pin != ($past(ctrl.output_level_ctrl) ^ $past(ctrl.output_invert))))
        else $error("forced inactive level wrong");

    // with the swap bit set compare A ends the period, so its match restarts the count
    a_pwm_swap_clr: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RULE_12
        (i_ce && is_pwm && ctrl.duty_period_swap && step && mt.match_a)
        |=> (count == stm_pkg::CNT_ZERO))
        else $error("swapped period did not clear the counter");
endmodule

// File: verification/tb_stm_timer.sv
`define check(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
    $display("BAD %0t got %0h exp %0h", $time, (got), (exp)); end end

module tb_stm_timer;
    timeunit 1ns;
    timeprecision 1ps;

    logic       i_mclk;
    logic       i_resetn;
    logic       i_ce;
    logic       i_tick;
    logic [2:0] i_addr;
    logic [7:0] i_wdata;
    logic       i_wr;
    logic       i_rd;
    logic [7:0] o_rdata;
    logic       o_pin;
    logic       o_pin_oe_n;
    logic       o_match_a_flag;
    logic       o_match_p_flag;
    int         n_fail;
    int         tests_run;
    int         cyc;

    stm_timer dut (
        .i_mclk         (i_mclk),
        .i_resetn       (i_resetn),
        .i_ce           (i_ce),
        .i_tick         (i_tick),
        .i_addr         (i_addr),
        .i_wdata        (i_wdata),
        .i_wr           (i_wr),
        .i_rd           (i_rd),
        .o_rdata        (o_rdata),
        .o_pin          (o_pin),
        .o_pin_oe_n     (o_pin_oe_n),
        .o_match_a_flag (o_match_a_flag),
        .o_match_p_flag (o_match_p_flag)
    );

    initial begin
        i_mclk = 1'b0;
        forever #20 i_mclk = ~i_mclk;
    end

    task automatic final_report();
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // whole run is about 73k cycles, dominated by the full 16-bit overflow
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_fail++;
            final_report();
        end
    end

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd   <= 1'b0;
        #1 d = o_rdata;
    endtask

    function automatic logic [7:0] c1(input logic [1:0] m, input logic [1:0] f,
                                       input logic l, input logic v, input logic s,
                                       input logic c);
        return {m, f, l, v, s, c};
    endfunction

    // mode and compare values only change while the counter is off
    task automatic setup(input logic [7:0] ctl, input logic [15:0] a, input logic [7:0] p);
        wr(stm_pkg::ADDR_CTRL0, 8'h00);
        wr(stm_pkg::ADDR_CTRL1, ctl);
        wr(stm_pkg::ADDR_CMPA_LO, a[7:0]);
        wr(stm_pkg::ADDR_CMPA_HI, a[15:8]);
        wr(stm_pkg::ADDR_CMPP, p);
        wr(stm_pkg::ADDR_FLAGS, 8'h03);
        wr(stm_pkg::ADDR_CTRL0, 8'h08);
    endtask

    task automatic wait_flag(input bit p, input int lim, output int n);
        n = 0;
        do begin
            @(posedge i_mclk);
            #1 n++;
        end while (((p ? o_match_p_flag : o_match_a_flag) !== 1'b1) && n < lim);
    endtask

    task automatic t_regs();
        logic [7:0] v;
        for (int a = 0; a < 8; a++) begin
            rd(3'(a), v);
            `check(v, 8'h00);
        end
        wr(stm_pkg::ADDR_CMPA_HI, 8'hA5);
        rd(stm_pkg::ADDR_CMPA_HI, v);
        `check(v, 8'hA5);
        wr(stm_pkg::ADDR_CMPP, 8'h5A);
        rd(stm_pkg::ADDR_CMPP, v);
        `check(v, 8'h5A);
        wr(stm_pkg::ADDR_CNT_LO, 8'h77);
        rd(stm_pkg::ADDR_CNT_LO, v);
        `check(v, 8'h00);
        // compare mode drives the pin even while the counter is stopped
        `check({o_pin_oe_n, o_match_a_flag, o_match_p_flag}, 3'h0);
    endtask

    task automatic t_pin_fn();
        logic [1:0] fn  [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
        logic       lvl [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
        logic       exp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        int         n;
        for (int i = 0; i < 4; i++) begin
            setup(c1(stm_pkg::STM_MODE_CMP, fn[i], lvl[i], 1'b0, 1'b0, 1'b1), 16'h0008, 8'h01);
            repeat (3) @(posedge i_mclk);
            #1 `check(o_pin, lvl[i]);
            `check(o_pin_oe_n, 1'b0);
            wait_flag(1'b0, 40, n);
            `check(o_match_a_flag, 1'b1);
            repeat (3) @(posedge i_mclk);
            #1 `check(o_pin, exp[i]);
            `check(o_match_p_flag, 1'b0);
        end
    endtask

    task automatic t_clr_p();
        int         n;
        int         m;
        logic [7:0] v;
        setup(c1(stm_pkg::STM_MODE_CMP, 2'h3, 1'b0, 1'b0, 1'b0, 1'b0), 16'h0010, 8'h01);
        wait_flag(1'b0, 300, n);
        `check(n >= 14 && n <= 20, 1'b1);
        repeat (2) @(posedge i_mclk);
        #1 `check(o_pin, 1'b1);
        wait_flag(1'b1, 400, m);
        `check(n + m + 2 >= 250 && n + m + 2 <= 262, 1'b1);
        `check(o_pin, 1'b1);
        `check(o_match_a_flag, 1'b1);
        rd(stm_pkg::ADDR_CNT_LO, v);
        `check(v < 8'h08, 1'b1);
    endtask

    task automatic t_clr_a();
        int n;
        setup(c1(stm_pkg::STM_MODE_CMP, 2'h2, 1'b0, 1'b0, 1'b0, 1'b1), 16'h0200, 8'h01);
        wait_flag(1'b0, 600, n);
        `check(n >= 505 && n <= 520, 1'b1);
        repeat (600) @(posedge i_mclk);
        #1 `check(o_match_p_flag, 1'b0);
        `check(o_pin, 1'b1);
    endtask

    task automatic t_count();
        logic [7:0] v1;
        logic [7:0] v2;
        int         c;
        int         n;
        setup(c1(stm_pkg::STM_MODE_TIMER, 2'h3, 1'b1, 1'b0, 1'b0, 1'b0), 16'h0000, 8'h00);
        repeat (3) @(posedge i_mclk);
        #1 `check(o_pin_oe_n, 1'b1);
        rd(stm_pkg::ADDR_CNT_LO, v1);
        c = cyc;
        repeat (10) @(posedge i_mclk);
        rd(stm_pkg::ADDR_CNT_LO, v2);
        `check(v2 - v1, 8'(cyc - c));
        @(posedge i_mclk);
        i_tick <= 1'b0;
        rd(stm_pkg::ADDR_CNT_LO, v1);
        repeat (10) @(posedge i_mclk);
        rd(stm_pkg::ADDR_CNT_LO, v2);
        `check(v2, v1);
        @(posedge i_mclk);
        i_tick <= 1'b1;
        wr(stm_pkg::ADDR_CTRL0, 8'h00);
        rd(stm_pkg::ADDR_CNT_LO, v1);
        repeat (10) @(posedge i_mclk);
        rd(stm_pkg::ADDR_CNT_LO, v2);
        `check(v2, v1);
        wr(stm_pkg::ADDR_CTRL0, 8'h08);
        rd(stm_pkg::ADDR_CNT_LO, v1);
        `check(v1 < 8'h04, 1'b1);
        // compare P of zero lets the counter run through the full 16-bit range
        wait_flag(1'b1, 70000, n);
        `check(n >= 65520 && n <= 65545, 1'b1);
        `check(o_match_a_flag, 1'b0);
    endtask

    task automatic t_pwm(input logic [7:0] ctl, input logic [15:0] a, input logic [7:0] p,
                         input int exp_hi, input logic exp_af);
        int hi;
        setup(ctl, a, p);
        repeat (300) @(posedge i_mclk);
        hi = 0;
        repeat (512) begin
            @(posedge i_mclk);
            #1 if (o_pin === 1'b1) hi++;
        end
        `check(hi, exp_hi);
        `check(o_match_p_flag, 1'b1);
        `check(o_match_a_flag, exp_af);
    endtask

    initial begin
        n_fail    = 0;
        tests_run = 0;
        cyc       = 0;
        i_resetn  = 1'b0;
        i_ce      = 1'b1;
        i_tick    = 1'b1;
        i_addr    = 3'h0;
        i_wdata   = 8'h00;
        i_wr      = 1'b0;
        i_rd      = 1'b0;
        repeat (10) @(posedge i_mclk);
        i_resetn <= 1'b1;
        t_regs();
        t_pin_fn();
        t_clr_p();
        t_clr_a();
        t_count();
        // clear source set to 1 on purpose: pwm must ignore it
        t_pwm(c1(stm_pkg::STM_MODE_PWM, 2'h2, 1'b1, 1'b0, 1'b0, 1'b1), 16'h0040, 8'h01, 128, 1'b1);
        t_pwm(c1(stm_pkg::STM_MODE_PWM, 2'h2, 1'b0, 1'b0, 1'b0, 1'b0), 16'h0040, 8'h01, 384, 1'b1);
        t_pwm(c1(stm_pkg::STM_MODE_PWM, 2'h2, 1'b1, 1'b1, 1'b0, 1'b0), 16'h0040, 8'h01, 384, 1'b1);
        t_pwm(c1(stm_pkg::STM_MODE_PWM, 2'h2, 1'b1, 1'b0, 1'b1, 1'b0), 16'h0200, 8'h01, 256, 1'b1);
        t_pwm(c1(stm_pkg::STM_MODE_PWM, 2'h2, 1'b1, 1'b0, 1'b0, 1'b0), 16'h0120, 8'h01, 512, 1'b0);
        t_pwm(c1(stm_pkg::STM_MODE_PWM, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0), 16'h0040, 8'h01, 0, 1'b1);
        t_pwm(c1(stm_pkg::STM_MODE_PWM, 2'h1, 1'b1, 1'b0, 1'b0, 1'b0), 16'h0040, 8'h01, 512, 1'b1);
        final_report();
    end
endmodule
